// [shared/ccdfe_cfg.svh]
/*
  Holds the register offsets, mode field positions, register reset values and frame and pipeline counts of the
  black-level control block as macros.
  Assumes inclusion by bare name from the package and design files.
*/
`ifndef CCDFE_CFG_SVH
`define CCDFE_CFG_SVH

// =====================================================
// serial register addresses
`define CCDFE_ADDR_MODE1 4'h0
`define CCDFE_ADDR_MODE2 4'h1
`define CCDFE_ADDR_MODE3 4'h2
`define CCDFE_ADDR_PGA 4'h3
`define CCDFE_ADDR_BLACK 4'h4
`define CCDFE_ADDR_TEST1 4'h8
`define CCDFE_ADDR_TEST2 4'h9
`define CCDFE_OP_WRITE 2'h0

// =====================================================
// reset values and black target range
`define CCDFE_MODE1_RST 10'h008
`define CCDFE_MODE2_RST 10'h000
`define CCDFE_MODE3_RST 10'h000
`define CCDFE_PGA_RST 10'h000
`define CCDFE_BLACK_RST 10'h040
`define CCDFE_BLACK_MIN 7'h10
`define CCDFE_BLACK_MAX 7'h7F

// =====================================================
// mode 1 fields
`define CCDFE_M1_PD 0
`define CCDFE_M1_BLRST 1
`define CCDFE_M1_OUTDIS 2
`define CCDFE_M1_LOWPWR 3
`define CCDFE_M1_DIRLO 4
`define CCDFE_M1_DIRHI 5

// =====================================================
// mode 2 fields
`define CCDFE_M2_MON_LO 0
`define CCDFE_M2_DCLAMP_OFF 3
`define CCDFE_M2_CTGT_LO 4
`define CCDFE_M2_FAST 7

// =====================================================
// mode 3 fields
`define CCDFE_M3_BPER_LO 0
`define CCDFE_M3_BFORCE 3
`define CCDFE_M3_CDSG_LO 4

// =====================================================
// frame and pipeline
`define CCDFE_FRAME_BITS 16
`define CCDFE_PIPE_STAGES 6
`define CCDFE_DATA_W 10

`endif

// [shared/ccdfe_pkg.sv]
/*
  Holds the types of the black-level control block.
  Assumes the config header is on the include path.
*/
`include "ccdfe_cfg.svh"
package ccdfe_pkg;
  typedef logic [`CCDFE_DATA_W-1:0] ccdfe_word_t;
  typedef enum logic [2:0] {
    CCDFE_SER_IDLE = 3'b001,
    CCDFE_SER_SHIFT = 3'b010,
    CCDFE_SER_DONE = 3'b100
  } ccdfe_ser_t;
  typedef enum logic [1:0] {
    CCDFE_MON_OFF = 2'h0,
    CCDFE_MON_CDS = 2'h1,
    CCDFE_MON_PGA = 2'h2,
    CCDFE_MON_INPUT = 2'h3
  } ccdfe_mon_t;
  typedef enum logic [1:0] {
    CCDFE_CAP_HOLD = 2'h0,
    CCDFE_CAP_CHARGE = 2'h1,
    CCDFE_CAP_DISCHARGE = 2'h2,
    CCDFE_CAP_CLEAR = 2'h3
  } ccdfe_cap_t;
endpackage

// [shared/ccdfe_wr_if.sv]
/*
  Carries decoded serial register writes from the main module to the
  register store.
  Assumes one clock for both ends.
*/
`timescale 1ns/10ps
interface ccdfe_wr_if;
  logic we;
  logic [3:0] addr;
  logic [9:0] data;
  modport src (output we, output addr, output data);
  modport dst (input we, input addr, input data);
endinterface

// [src/ccdfe_regs.sv]
/*
  Holds the five control registers written by the serial port.
  Assumes writes arrive one cycle wide and reset is synchronous.
*/
`timescale 1ns/10ps
`include "ccdfe_cfg.svh"
module ccdfe_regs (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // write side
  ccdfe_wr_if.dst wr,
  // register contents
  output ccdfe_pkg::ccdfe_word_t mode1,
  output ccdfe_pkg::ccdfe_word_t mode2,
  output ccdfe_pkg::ccdfe_word_t mode3,
  output ccdfe_pkg::ccdfe_word_t pga,
  output ccdfe_pkg::ccdfe_word_t black
);
  import ccdfe_pkg::*;
  typedef struct packed {
    ccdfe_word_t m1;
    ccdfe_word_t m2;
    ccdfe_word_t m3;
    ccdfe_word_t pg;
    ccdfe_word_t bl;
  } ccdfe_regs_st_t;
  ccdfe_regs_st_t s_q, s_d;

  // =====================================================
  // write decode
  always_comb begin
    s_d = s_q;
    if (wr.we) begin
      case (wr.addr)
        `CCDFE_ADDR_MODE1: s_d.m1 = wr.data;
        `CCDFE_ADDR_MODE2: s_d.m2 = wr.data;
        `CCDFE_ADDR_MODE3: s_d.m3 = wr.data;
        `CCDFE_ADDR_PGA: s_d.pg = wr.data;
        `CCDFE_ADDR_BLACK: begin
          // target clipped into its legal range
          if (wr.data[6:0] < `CCDFE_BLACK_MIN) begin
            s_d.bl = {3'h0, `CCDFE_BLACK_MIN};
          end else begin
            s_d.bl = {3'h0, wr.data[6:0]};
          end
        end
        default: s_d = s_q;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '{`CCDFE_MODE1_RST, `CCDFE_MODE2_RST, `CCDFE_MODE3_RST,
               `CCDFE_PGA_RST, `CCDFE_BLACK_RST};
    end else begin
      s_q <= s_d;
    end
  end

  assign mode1 = s_q.m1;
  assign mode2 = s_q.m2;
  assign mode3 = s_q.m3;
  assign pga = s_q.pg;
  assign black = s_q.bl;
endmodule

// [src/ccdfe_ctrl.sv]
/*
  Digital control of a sensor front end: serial port, clamp and sampling
  steering, black-level loop with boost, output pipeline and tri-state.
  Assumes all pins are synchronous to clk (the converter sample clock).
*/
`timescale 1ns/10ps
`include "ccdfe_cfg.svh"
// Summary of operation
// - reference then pixel sample, subtract
// - two-bit sampling gain, nine-bit amplifier gain
// - one bit picks normal or fast clamp
// - two bits choose clamped inputs or none
// - direct clamp pulse: clamp or calibration gate
// - direct-path clamp disable bit, independent
// - black target 16 to 127, default 64
// - during black pulse compare, charge or discharge
// - clear integration on reset bit, pin, powerdown
// - amplifier routing: cancel during direct clamp
// - boost period counts 1 to 7 pulses
// - force bit keeps boost; defaults keep low
// - chip select starts the boost pulse count
// - ten-bit straight binary output coding
// - result appears after 7 clock pipeline
// - outputs float on disable, standby, powerdown
// - two bits route the direct input
// - direct routing ignores blanking and sample pulses
// - powerdown is register bit OR standby
// - two bits select the monitor source
// - sixteen-bit write, executed on select rise
// - low-power bit defaults to one
module ccdfe_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  input wire logic reset_n,
  input wire logic standby_n,
  // serial port
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic serial_select_n,
  // timing pulses
  input wire logic ref_sample_pulse,
  input wire logic pixel_sample_pulse,
  input wire logic blanking_pulse,
  input wire logic optical_black_pulse,
  input wire logic sensor_clamp_pulse,
  input wire logic direct_clamp_pulse,
  // converter result
  input wire ccdfe_pkg::ccdfe_word_t conv_code,
  // analog steering
  output logic ref_hold,
  output logic pixel_hold,
  output logic blank_gate,
  output logic [1:0] cds_gain,
  output logic [8:0] pga_gain,
  output logic fast_clamp,
  output logic clamp_ref_en,
  output logic clamp_pixel_en,
  output logic direct_clamp_en,
  output logic direct_to_amp,
  output logic direct_to_conv,
  output ccdfe_pkg::ccdfe_mon_t monitor_sel,
  output logic low_power,
  output logic power_down,
  // black loop
  output ccdfe_pkg::ccdfe_cap_t black_integration_cap,
  output logic boost_gain,
  // data outputs
  output ccdfe_pkg::ccdfe_word_t data_out,
  output logic [9:0] data_oe
);
  import ccdfe_pkg::*;

  typedef struct packed {
    ccdfe_ser_t st;
    logic [15:0] sh;
    logic [4:0] cnt;
    logic sck_prev;
    logic obp_prev;
    logic [2:0] bcnt;
    logic [`CCDFE_PIPE_STAGES*10-1:0] pipe;
    logic ref_hold;
    logic pixel_hold;
    logic blank_gate;
    logic [1:0] cds_gain;
    logic [8:0] pga_gain;
    logic fast_clamp;
    logic clamp_ref_en;
    logic clamp_pixel_en;
    logic direct_clamp_en;
    logic direct_to_amp;
    logic direct_to_conv;
    ccdfe_mon_t mon;
    logic low_power;
    logic pd;
    ccdfe_cap_t cap;
    logic boost;
    ccdfe_word_t dout;
    logic [9:0] oe;
  } ccdfe_st_t;

  ccdfe_st_t s_q, s_d;
  ccdfe_wr_if wr_bus ();
  ccdfe_word_t mode1, mode2, mode3, pga, black;
  logic rst;
  logic dir_any;
  logic calib_win;
  logic sck_rise;
  logic obp_rise;
  logic amp_route;
  logic conv_route;
  logic pd_now;
  logic out_off;
  logic black_clear;
  logic code_below;
  logic code_above;
  logic frame_full;
  logic frame_start;
  logic [2:0] boost_period;
  logic boost_force;
  logic [1:0] clamp_target;

  // register file also cleared by the reset pin
  assign rst = srst | ~reset_n;

  ccdfe_regs ccdfe_regs_i (
    .clk(clk),
    .rst(rst),
    .wr(wr_bus),
    .mode1(mode1),
    .mode2(mode2),
    .mode3(mode3),
    .pga(pga),
    .black(black)
  );

  // =====================================================
  // serial write decode
  assign wr_bus.we = (s_q.st == CCDFE_SER_DONE) && (s_q.sh[15:14] == `CCDFE_OP_WRITE);
  assign wr_bus.addr = s_q.sh[13:10];
  assign wr_bus.data = s_q.sh[9:0];

  assign sck_rise = serial_clk & ~s_q.sck_prev;
  assign obp_rise = optical_black_pulse & ~s_q.obp_prev;
  assign dir_any = mode1[`CCDFE_M1_DIRHI] | mode1[`CCDFE_M1_DIRLO];
  // in amplifier routing the direct clamp pulse opens the black window
  assign calib_win = amp_route ? direct_clamp_pulse
                     : optical_black_pulse;

  // =====================================================
  // mode field decode
  assign amp_route = mode1[`CCDFE_M1_DIRLO] & ~mode1[`CCDFE_M1_DIRHI];
  assign conv_route = mode1[`CCDFE_M1_DIRHI];
  assign pd_now = mode1[`CCDFE_M1_PD] | ~standby_n;
  assign out_off = mode1[`CCDFE_M1_OUTDIS] | pd_now;
  // clear wins over any compare result
  assign black_clear = mode1[`CCDFE_M1_BLRST] | ~reset_n | pd_now;
  assign boost_period = mode3[`CCDFE_M3_BPER_LO +: 3];
  assign boost_force = mode3[`CCDFE_M3_BFORCE];
  assign clamp_target = mode2[`CCDFE_M2_CTGT_LO +: 2];

  // =====================================================
  // black level compare
  assign code_below = conv_code < black;
  assign code_above = conv_code > black;

  // =====================================================
  // serial frame events
  // select fall seen while idle: a new access begins
  assign frame_start = (s_q.st == CCDFE_SER_IDLE) && !serial_select_n;
  // longer frames keep only the last sixteen bits
  assign frame_full = s_q.cnt >= 5'(`CCDFE_FRAME_BITS);

  // =====================================================
  // next state
  always_comb begin
    s_d = s_q;
    s_d.sck_prev = serial_clk;
    s_d.obp_prev = optical_black_pulse;

    // =====================================================
    // serial shifter
    case (s_q.st)
      CCDFE_SER_IDLE: begin
        s_d.cnt = 5'h00;
        if (!serial_select_n) begin
          s_d.st = CCDFE_SER_SHIFT;
        end
      end
      CCDFE_SER_SHIFT: begin
        if (sck_rise && !serial_select_n) begin
          s_d.sh = {s_q.sh[14:0], serial_data};
          if (s_q.cnt != 5'h1F) begin
            s_d.cnt = s_q.cnt + 5'h01;
          end
        end
        if (serial_select_n) begin
          // short frames are dropped at the select rise
          s_d.st = frame_full ? CCDFE_SER_DONE : CCDFE_SER_IDLE;
        end
      end
      CCDFE_SER_DONE: s_d.st = CCDFE_SER_IDLE;
      default: s_d.st = CCDFE_SER_IDLE;
    endcase

    // =====================================================
    // boost counter: select fall restarts it, each black pulse rise counts
    if (frame_start) begin
      s_d.bcnt = boost_period;
    end else if (obp_rise && s_q.bcnt != 3'h0) begin
      s_d.bcnt = s_q.bcnt - 3'h1;
    end
    s_d.boost = boost_force | (s_q.bcnt != 3'h0);

    // =====================================================
    // sampling gates; direct routing masks the pulses
    s_d.ref_hold = ref_sample_pulse & ~dir_any;
    s_d.pixel_hold = pixel_sample_pulse & ~dir_any;
    s_d.blank_gate = blanking_pulse & ~dir_any;
    s_d.cds_gain = mode3[`CCDFE_M3_CDSG_LO +: 2];
    s_d.pga_gain = pga[8:0];

    // =====================================================
    // clamps
    s_d.fast_clamp = mode2[`CCDFE_M2_FAST];
    s_d.clamp_ref_en = sensor_clamp_pulse & ~dir_any
                       & clamp_target[0];
    s_d.clamp_pixel_en = sensor_clamp_pulse & ~dir_any
                         & clamp_target[1];
    s_d.direct_clamp_en = direct_clamp_pulse & dir_any
                          & ~mode2[`CCDFE_M2_DCLAMP_OFF];
    s_d.direct_to_conv = conv_route;
    s_d.direct_to_amp = amp_route;
    s_d.mon = ccdfe_mon_t'(mode2[`CCDFE_M2_MON_LO +: 2]);
    s_d.low_power = mode1[`CCDFE_M1_LOWPWR];
    s_d.pd = pd_now;

    // =====================================================
    // black integration
    if (black_clear) begin
      s_d.cap = CCDFE_CAP_CLEAR;
    end else if (calib_win && !conv_route) begin
      if (code_below) begin
        s_d.cap = CCDFE_CAP_CHARGE;
      end else if (code_above) begin
        s_d.cap = CCDFE_CAP_DISCHARGE;
      end else begin
        s_d.cap = CCDFE_CAP_HOLD;
      end
    end else begin
      s_d.cap = CCDFE_CAP_HOLD;
    end

    // =====================================================
    // straight binary passes unchanged through the pipeline
    s_d.pipe = {s_q.pipe[`CCDFE_PIPE_STAGES*10-11:0], conv_code};
    s_d.dout = s_q.pipe[`CCDFE_PIPE_STAGES*10-1 -: 10];
    s_d.oe = {10{~out_off}};
  end

  // =====================================================
  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.st <= CCDFE_SER_IDLE;
      s_q.sck_prev <= 1'b1;
      s_q.low_power <= 1'b1;
      s_q.cap <= CCDFE_CAP_CLEAR;
    end else begin
      s_q <= s_d;
    end
  end

  // =====================================================
  // outputs
  assign ref_hold = s_q.ref_hold;
  assign pixel_hold = s_q.pixel_hold;
  assign blank_gate = s_q.blank_gate;
  assign cds_gain = s_q.cds_gain;
  assign pga_gain = s_q.pga_gain;
  assign fast_clamp = s_q.fast_clamp;
  assign clamp_ref_en = s_q.clamp_ref_en;
  assign clamp_pixel_en = s_q.clamp_pixel_en;
  assign direct_clamp_en = s_q.direct_clamp_en;
  assign direct_to_amp = s_q.direct_to_amp;
  assign direct_to_conv = s_q.direct_to_conv;
  assign monitor_sel = s_q.mon;
  assign low_power = s_q.low_power;
  assign power_down = s_q.pd;
  assign black_integration_cap = s_q.cap;
  assign boost_gain = s_q.boost;
  assign data_out = s_q.dout;

  // per-pin enable, each pin from its own flop
  for (genvar b = 0; b < `CCDFE_DATA_W; b++) begin : g_oe
    assign data_oe[b] = s_q.oe[b];
  end
endmodule

// [tb/ccdfe_ctl_model.sv]
/* Serial side of the timing controller: sends one frame of nbits bits of word per go.
   Assumes one clock shared with the block. */
`timescale 1ns/10ps
module ccdfe_ctl_model (
  // clock
  input wire logic clk,
  // command
  input wire logic go,
  input wire logic [15:0] word,
  input wire logic [4:0] nbits,
  output logic busy,
  // serial pins
  output logic serial_clk,
  output logic serial_data,
  output logic serial_select_n
);
  logic [15:0] sh;
  logic [5:0] ph;
  initial begin
    {busy, serial_clk, serial_data, serial_select_n} = 4'h1;
  end
  always @(posedge clk) begin
    if (go && !busy) begin
      busy <= 1'b1;
      sh <= word;
      ph <= 6'h00;
      serial_select_n <= 1'b0;
    end else if (busy) begin
      ph <= ph + 6'h01;
      if (ph < {nbits, 1'b0}) begin
        serial_clk <= ph[0];
        if (!ph[0]) begin
          serial_data <= sh[15];
        end else begin
          sh <= {sh[14:0], 1'b0};
        end
      end else if (ph == {nbits, 1'b0}) begin
        serial_select_n <= 1'b1;
        serial_clk <= 1'b0;
        // released line: never leave the last bit standing
        serial_data <= ~serial_data;
      end else if (ph == {nbits, 1'b0} + 6'h06) begin
        busy <= 1'b0;
      end
    end
  end
endmodule

// [tb/ccdfe_chk.sv]
/* Port checker of the black-level control block.
   Assumes it is bound onto ccdfe_ctrl and shares its port names. */
`timescale 1ns/10ps
module ccdfe_chk (
  // clock and resets
  input wire logic clk,
  input wire logic srst,
  input wire logic reset_n,
  input wire logic standby_n,
  // pulses and code
  input wire logic ref_sample_pulse,
  input wire logic sensor_clamp_pulse,
  input wire logic direct_clamp_pulse,
  input wire logic optical_black_pulse,
  input wire ccdfe_pkg::ccdfe_word_t conv_code,
  // outputs
  input wire logic ref_hold,
  input wire logic clamp_ref_en,
  input wire logic direct_clamp_en,
  input wire logic direct_to_amp,
  input wire logic direct_to_conv,
  input wire logic low_power,
  input wire logic power_down,
  input wire ccdfe_pkg::ccdfe_cap_t black_integration_cap,
  input wire ccdfe_pkg::ccdfe_word_t data_out,
  input wire logic [9:0] data_oe
);
  import ccdfe_pkg::*;
  // =====================================
  // clean cycles since reset, so the pipe check never sees pre-reset data
  logic [2:0] cyc_q;
  logic [2:0] cyc_d;
  always_comb cyc_d = (cyc_q == 3'h7) ? cyc_q : cyc_q + 3'h1;
  always_ff @(posedge clk) cyc_q <= (srst || !reset_n) ? 3'h0 : cyc_d;
  default clocking @(posedge clk); endclocking
  default disable iff (srst || !reset_n);
  sequence s_sb_low;
    !standby_n ##1 !standby_n;
  endsequence
  // =====================================
  // properties
  a_pipe_delay: assert property (cyc_q == 3'h7 |-> data_out == $past(conv_code, 7))
    else $error("pipe delay");
  a_pd_standby: assert property (!standby_n |=> power_down)
    else $error("standby power down");
  a_oe_standby: assert property (s_sb_low |=> data_oe == 10'h000)
    else $error("outputs driven in standby");
  a_cap_idle: assert property (!optical_black_pulse && !direct_clamp_pulse |=>
    black_integration_cap inside {CCDFE_CAP_HOLD, CCDFE_CAP_CLEAR}) else $error("cap moved outside window");
  a_ref_hold: assert property (ref_hold |-> $past(ref_sample_pulse) && !direct_to_amp && !direct_to_conv)
    else $error("ref hold");
  a_clamp_src: assert property (clamp_ref_en |-> $past(sensor_clamp_pulse) && !direct_to_conv)
    else $error("clamp source");
  a_dclamp_src: assert property (direct_clamp_en |-> $past(direct_clamp_pulse) && (direct_to_amp || direct_to_conv))
    else $error("direct clamp source");
  a_reset_lowpwr: assert property (disable iff (1'b0) (srst || !reset_n) |=> low_power)
    else $error("low power after reset");
endmodule
bind ccdfe_ctrl ccdfe_chk ccdfe_chk_i (.*);

// [tb/ccdfe_ctrl_bench.sv]
/* Bench of the black-level control block: serial writes, pulses, checks.
   Assumes the serial model and checker are compiled first. */
`timescale 1ns/10ps
`define CHK(g, e) cmp(16'(g), 16'(e))
module ccdfe_ctrl_bench;
  import ccdfe_pkg::*;
  logic clk = 1'b0, srst = 1'b1, reset_n = 1'b1, standby_n = 1'b1, go = 1'b0;
  logic ref_sample_pulse = 1'b0, pixel_sample_pulse = 1'b0, blanking_pulse = 1'b0;
  logic optical_black_pulse = 1'b0, sensor_clamp_pulse = 1'b0, direct_clamp_pulse = 1'b0;
  logic serial_clk, serial_data, serial_select_n, busy, ref_hold, pixel_hold, blank_gate;
  logic fast_clamp, clamp_ref_en, clamp_pixel_en, direct_clamp_en, direct_to_amp, direct_to_conv;
  logic low_power, power_down, boost_gain;
  logic [15:0] word = 16'h0000;
  logic [4:0] nbits = 5'h10;
  logic [1:0] cds_gain;
  logic [8:0] pga_gain;
  logic [9:0] data_oe;
  ccdfe_word_t conv_code = 10'h3FF, data_out;
  ccdfe_mon_t monitor_sel;
  ccdfe_cap_t black_integration_cap;
  int mismatches = 0, checked = 0, cyc_cnt = 0;
  ccdfe_ctl_model ccdfe_ctl_model_i (.*);
  ccdfe_ctrl ccdfe_ctrl_i (.*);
  always #20 clk = ~clk;
  // =====================================
  // report and limits
  task automatic stop_test();
    if (mismatches == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 6000) begin
      mismatches++;
      stop_test();
    end
  end
  // =====================================
  // access tasks; each ends at a falling edge with outputs settled
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic ws(input logic [15:0] w, input logic [4:0] n);
    int k;
    k = 0;
    @(posedge clk);
    go <= 1'b1;
    word <= w;
    nbits <= n;
    @(posedge clk);
    go <= 1'b0;
    do begin
      @(negedge clk);
      k++;
    end while (busy && k < 100);
    `CHK(busy, 1'b0);
  endtask
  task automatic wr(input logic [3:0] a, input logic [9:0] d);
    ws({2'h0, a, d}, 5'h10);
  endtask
  task automatic ob(input logic [9:0] c, input ccdfe_cap_t e);
    @(posedge clk);
    conv_code <= c;
    tick(1);
    `CHK(black_integration_cap, e);
  endtask
  task automatic obpulse(input int n);
    repeat (n) begin
      @(posedge clk);
      optical_black_pulse <= 1'b1;
      @(posedge clk);
      optical_black_pulse <= 1'b0;
    end
    tick(2);
  endtask
  // =====================================
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    tick(2);
    `CHK({low_power, data_oe}, 11'h7FF);
    @(posedge clk);
    conv_code <= 10'h000;
    tick(6);
    `CHK(data_out, 10'h3FF);
    tick(1);
    `CHK(data_out, 10'h000);
    @(posedge clk);
    optical_black_pulse <= 1'b1;
    ob(10'h03F, CCDFE_CAP_CHARGE);
    ob(10'h040, CCDFE_CAP_HOLD);
    ob(10'h041, CCDFE_CAP_DISCHARGE);
    wr(4'h4, 10'h005);
    ob(10'h00F, CCDFE_CAP_CHARGE);
    ob(10'h010, CCDFE_CAP_HOLD);
    wr(4'h4, 10'h07F);
    ob(10'h080, CCDFE_CAP_DISCHARGE);
    wr(4'h0, 10'h00A);
    ob(10'h000, CCDFE_CAP_CLEAR);
    wr(4'h0, 10'h00C);
    `CHK(data_oe, 10'h000);
    wr(4'h0, 10'h009);
    `CHK({power_down, data_oe}, 11'h400);
    ob(10'h000, CCDFE_CAP_CLEAR);
    wr(4'h0, 10'h008);
    @(posedge clk);
    standby_n <= 1'b0;
    tick(2);
    `CHK({power_down, data_oe, black_integration_cap}, 13'h1003);
    @(posedge clk);
    standby_n <= 1'b1;
    optical_black_pulse <= 1'b0;
    // period only takes effect at the next access
    wr(4'h2, 10'h033);
    `CHK({cds_gain, boost_gain}, 3'h6);
    wr(4'h3, 10'h1FF);
    `CHK({pga_gain, boost_gain}, 10'h3FF);
    obpulse(2);
    `CHK(boost_gain, 1'b1);
    obpulse(1);
    `CHK(boost_gain, 1'b0);
    wr(4'h3, 10'h000);
    `CHK(boost_gain, 1'b1);
    wr(4'h2, 10'h008);
    obpulse(4);
    `CHK(boost_gain, 1'b1);
    wr(4'h2, 10'h000);
    `CHK(boost_gain, 1'b0);
    ws({2'h0, 4'h3, 10'h155}, 5'h0F);
    ws({2'h1, 4'h3, 10'h155}, 5'h10);
    `CHK(pga_gain, 9'h000);
    @(posedge clk);
    sensor_clamp_pulse <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(4'h1, 10'((i[0] << 7) | (i << 4) | i));
      `CHK({fast_clamp, clamp_pixel_en, clamp_ref_en, monitor_sel}, 5'((i[0] << 4) | (i << 2) | i));
    end
    @(posedge clk);
    ref_sample_pulse <= 1'b1;
    @(posedge clk);
    pixel_sample_pulse <= 1'b1;
    blanking_pulse <= 1'b1;
    direct_clamp_pulse <= 1'b1;
    wr(4'h0, 10'h028);
    `CHK({direct_to_conv, direct_to_amp, direct_clamp_en, clamp_ref_en, ref_hold, pixel_hold, blank_gate}, 7'h50);
    wr(4'h1, 10'h008);
    `CHK(direct_clamp_en, 1'b0);
    wr(4'h0, 10'h018);
    `CHK({direct_to_amp, black_integration_cap}, {1'b1, CCDFE_CAP_CHARGE});
    wr(4'h0, 10'h038);
    `CHK({direct_to_conv, direct_to_amp, black_integration_cap}, 4'h8);
    wr(4'h0, 10'h008);
    `CHK({ref_hold, pixel_hold, blank_gate, clamp_ref_en}, 4'hE);
    wr(4'h3, 10'h1FF);
    @(posedge clk);
    reset_n <= 1'b0;
    tick(2);
    `CHK({low_power, pga_gain, black_integration_cap}, 12'h803);
    stop_test();
  end
endmodule
